/* File: inc/mrf_params.svh */
// Constants for the receive mode and filter control block of the MAC.
// Assumes a 100 MHz core clock and nibble-wide MII data.
`ifndef MRF_PARAMS_SVH
`define MRF_PARAMS_SVH

// Control register index on the indirect CSR port
`define MRF_IDX_CTRL 8'h01
`define MRF_CTRL_RESET 32'h0004_0000
// Bits that hold state; everything else reads zero
`define MRF_CTRL_WMASK 32'h80bf_a000

// Field positions inside the control register
`define MRF_BIT_RECEIVE_EVERY 31
`define MRF_BIT_BLOCK_SELF 23
`define MRF_BIT_LOOP_SELECT 21
`define MRF_BIT_FULL_DUPLEX 20
`define MRF_BIT_PASS_MCAST 19
`define MRF_BIT_ANY_DEST 18
`define MRF_BIT_INVERT 17
`define MRF_BIT_FWD_DAMAGED 16
`define MRF_BIT_HASH_ALL 15
`define MRF_BIT_HASH_EXACT 13

// Loopback settling time and core clock period
`define MRF_LOOP_SETTLE_NS 10000
`define MRF_CLK_PERIOD_NS 10

// Frame layout in nibbles
`define MRF_DA_NIBBLES 12'h00c
`define MRF_MIN_FRAME_NIBBLES 12'h080
`define MRF_FLUSH_LAST 4'hb
`define MRF_PREAMBLE_NIB 4'h5
`define MRF_SFD_NIB 4'hd

// Reflected Ethernet CRC
`define MRF_CRC_POLY 32'hedb8_8320
`define MRF_CRC_INIT 32'hffff_ffff

`endif

/* File: inc/mrf_pkg.sv */
// Types shared by the receive mode and filter control block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package mrf_pkg;
  typedef logic [31:0] mrf_word_t;
  typedef logic [3:0] mrf_nib_t;
  typedef enum logic [2:0] {RX_IDLE, RX_PREAMBLE, RX_DATA, RX_FLUSH, RX_END} mrf_rx_state_t;
endpackage
`default_nettype wire

/* File: hw/mrf_sync.sv */
// Two-stage synchroniser for a group of pin levels.
// Assumes the inputs are levels from outside the core clock domain.
`timescale 1ns/10ps
`default_nettype none
module mrf_sync #(
  parameter int W = 8
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      meta_ff <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* File: hw/mrf_crc_nib.sv */
// Running reflected CRC over nibbles, used for the hash filter index.
// Assumes nibbles arrive least significant bit first, one per enable.
`timescale 1ns/10ps
`default_nettype none
`include "mrf_params.svh"
module mrf_crc_nib (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic init_in,
  input wire logic en_in,
  input wire mrf_pkg::mrf_nib_t nib_in,
  output var mrf_pkg::mrf_word_t crc_out
);
  import mrf_pkg::*;

  // One nibble, four serial steps of the reflected polynomial
  function automatic mrf_word_t crc_step(input mrf_word_t crc, input mrf_nib_t nib);
    mrf_word_t c;
    c = crc;
    for (int i = 0; i < 4; i++)
    begin
      if (c[0] ^ nib[i])
        c = (c >> 1) ^ `MRF_CRC_POLY;
      else
        c = c >> 1;
    end
    return c;
  endfunction

  // Init wins over a nibble in the same cycle
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in || init_in)
      crc_out <= `MRF_CRC_INIT;
    else if (en_in)
      crc_out <= crc_step(crc_out, nib_in);
  end
endmodule
`default_nettype wire

/* File: hw/mrf_mac_ctrl.sv */
// Control register of the MAC with the receive filter, loopback and duplex logic it steers.
// Assumes the indirect CSR port, station address and hash table come from the core clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "mrf_params.svh"
module mrf_mac_ctrl #(
  parameter int CNT_W = 12
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic csr_sel_in,
  input wire logic csr_rnw_in,
  input wire logic [7:0] csr_index_in,
  input wire mrf_pkg::mrf_word_t csr_wdata_in,
  output var logic csr_ack_out,
  output var mrf_pkg::mrf_word_t csr_rdata_out,
  input wire logic [47:0] station_addr_in,
  input wire logic [63:0] hash_table_in,
  input wire logic tx_stb_in,
  input wire logic tx_en_in,
  input wire mrf_pkg::mrf_nib_t tx_data_in,
  input wire logic heartbeat_fail_in,
  input wire logic mii_rx_clk_in,
  input wire logic mii_rx_dv_in,
  input wire logic mii_rx_er_in,
  input wire logic mii_col_in,
  input wire mrf_pkg::mrf_nib_t mii_rxd_in,
  output var logic mii_tx_en_out,
  output var mrf_pkg::mrf_nib_t mii_txd_out,
  output var mrf_pkg::mrf_nib_t rx_data_out,
  output var logic rx_valid_out,
  output var logic rx_end_out,
  output var logic rx_keep_out,
  output var logic rx_filter_fail_out,
  output var logic rx_bad_out,
  output var logic hb_fail_out,
  output var logic tx_defer_out,
  output var logic loop_active_out
);
  import mrf_pkg::*;

  localparam int SETTLE_CYC = `MRF_LOOP_SETTLE_NS / `MRF_CLK_PERIOD_NS;
  localparam logic [9:0] SETTLE_LAST = 10'(SETTLE_CYC - 1);

  mrf_word_t ctrl_ff;
  logic [7:0] pin_sync;
  logic rxclk_prev_ff;
  logic pin_stb;
  logic [9:0] settle_cnt_ff;
  logic tx_en_ff;
  logic src_stb;
  logic src_dv;
  logic src_er;
  mrf_nib_t src_d;
  logic self_block;
  mrf_rx_state_t rx_state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [3:0] flush_ff;
  logic [47:0] da_ff;
  mrf_nib_t dly_ff [0:11];
  logic shift;
  logic capture;
  logic fwd_ff;
  logic pass_ff;
  logic bad_ff;
  logic abort_ff;
  mrf_word_t crc;
  logic is_mcast;
  logic perfect_hit;
  logic addr_hit;
  logic pass_now;
  logic fwd_now;
  logic fwd_use;

  // Control register: masked write, reserved bits stay zero
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      ctrl_ff <= `MRF_CTRL_RESET;
    else if (csr_sel_in && !csr_rnw_in && csr_index_in == `MRF_IDX_CTRL)
      ctrl_ff <= csr_wdata_in & `MRF_CTRL_WMASK;
  end

  // Every request is answered next cycle; other indexes read zero
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      csr_ack_out <= 1'b0;
      csr_rdata_out <= '0;
    end
    else
    begin
      csr_ack_out <= csr_sel_in;
      if (csr_sel_in && csr_rnw_in)
        csr_rdata_out <= (csr_index_in == `MRF_IDX_CTRL) ? ctrl_ff : '0;
    end
  end

  // MII pins cross in as levels; data skew is covered by sampling on the synced clock edge
  mrf_sync #(.W(8)) u_pin_sync (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .async_in({mii_rx_clk_in, mii_rx_dv_in, mii_rx_er_in, mii_col_in, mii_rxd_in}),
    .sync_out(pin_sync)
  );

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      rxclk_prev_ff <= 1'b0;
    else
      rxclk_prev_ff <= pin_sync[7];
  end
  assign pin_stb = pin_sync[7] & ~rxclk_prev_ff;

  // Loop mode follows the select bit only after the settling time has run out
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      settle_cnt_ff <= '0;
      loop_active_out <= 1'b0;
    end
    else if (ctrl_ff[`MRF_BIT_LOOP_SELECT] == loop_active_out)
      settle_cnt_ff <= '0;
    else if (settle_cnt_ff == SETTLE_LAST)
    begin
      settle_cnt_ff <= '0;
      loop_active_out <= ctrl_ff[`MRF_BIT_LOOP_SELECT];
    end
    else
      settle_cnt_ff <= settle_cnt_ff + 10'h001;
  end

  // Transmit toward the PHY; silenced while looping back
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      tx_en_ff <= 1'b0;
      mii_tx_en_out <= 1'b0;
      mii_txd_out <= '0;
    end
    else
    begin
      if (tx_stb_in)
        tx_en_ff <= tx_en_in;
      if (loop_active_out)
      begin
        mii_tx_en_out <= 1'b0;
        mii_txd_out <= '0;
      end
      else if (tx_stb_in)
      begin
        mii_tx_en_out <= tx_en_in;
        mii_txd_out <= tx_data_in;
      end
    end
  end

  // Receive source: the PHY, or our own transmit stream in loopback
  assign src_stb = loop_active_out ? tx_stb_in : pin_stb;
  assign src_dv = loop_active_out ? tx_en_in : pin_sync[6];
  assign src_er = loop_active_out ? 1'b0 : (pin_sync[5] | pin_sync[4]);
  assign src_d = loop_active_out ? tx_data_in : pin_sync[3:0];
  // Own frames are dropped only when asked; otherwise they pass like any other
  assign self_block = ctrl_ff[`MRF_BIT_BLOCK_SELF] & tx_en_ff;

  // Half duplex must not start sending over a live carrier
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      tx_defer_out <= 1'b0;
      hb_fail_out <= 1'b0;
    end
    else
    begin
      tx_defer_out <= ~ctrl_ff[`MRF_BIT_FULL_DUPLEX] & pin_sync[6];
      hb_fail_out <= heartbeat_fail_in & ~ctrl_ff[`MRF_BIT_FULL_DUPLEX];
    end
  end

  assign capture = rx_state_ff == RX_DATA && src_stb && src_dv && !self_block;
  assign shift = capture || rx_state_ff == RX_FLUSH;

  mrf_crc_nib u_crc (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .init_in(rx_state_ff != RX_DATA),
    .en_in(capture && cnt_ff < `MRF_DA_NIBBLES),
    .nib_in(src_d),
    .crc_out(crc)
  );

  // Address decision, valid once the whole destination has arrived
  always_comb
  begin
    is_mcast = da_ff[0];
    perfect_hit = da_ff == station_addr_in;
    if (ctrl_ff[`MRF_BIT_HASH_ALL])
      addr_hit = hash_table_in[crc[31:26]];
    else if (ctrl_ff[`MRF_BIT_HASH_EXACT] && is_mcast)
      addr_hit = hash_table_in[crc[31:26]];
    else
      addr_hit = perfect_hit;
    if (ctrl_ff[`MRF_BIT_INVERT] && !ctrl_ff[`MRF_BIT_HASH_EXACT] && !ctrl_ff[`MRF_BIT_HASH_ALL])
      addr_hit = ~addr_hit;
    pass_now = ctrl_ff[`MRF_BIT_ANY_DEST]
      | (ctrl_ff[`MRF_BIT_PASS_MCAST] & is_mcast)
      | addr_hit;
    fwd_now = ctrl_ff[`MRF_BIT_RECEIVE_EVERY] | pass_now;
  end
  assign fwd_use = (cnt_ff == `MRF_DA_NIBBLES) ? fwd_now : fwd_ff;

  // Destination shift and a twelve-nibble delay so nothing leaves before the verdict
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      da_ff <= '0;
      dly_ff[0] <= '0;
    end
    else if (shift)
    begin
      if (capture && cnt_ff < `MRF_DA_NIBBLES)
        da_ff <= {src_d, da_ff[47:4]};
      dly_ff[0] <= src_d;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < 12; gi++)
    begin : g_dly
      always_ff @(posedge core_clk_in)
      begin
        if (!resetn_in)
          dly_ff[gi] <= '0;
        else if (shift)
          dly_ff[gi] <= dly_ff[gi-1];
      end
    end
  endgenerate

  // Receive framing: strip preamble, count nibbles, flush the delay, then report
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      rx_state_ff <= RX_IDLE;
      cnt_ff <= '0;
      flush_ff <= '0;
      bad_ff <= 1'b0;
      abort_ff <= 1'b0;
    end
    else
    begin
      case (rx_state_ff)
        RX_IDLE:
        begin
          cnt_ff <= '0;
          bad_ff <= 1'b0;
          // A frame cut by our own transmit stays ignored until its carrier drops
          abort_ff <= src_dv & (abort_ff | (src_stb & self_block));
          if (src_stb && src_dv && !self_block && !abort_ff)
            rx_state_ff <= (src_d == `MRF_SFD_NIB) ? RX_DATA : RX_PREAMBLE;
        end
        RX_PREAMBLE:
        begin
          if (src_stb && (!src_dv || self_block))
          begin
            abort_ff <= self_block;
            rx_state_ff <= RX_IDLE;
          end
          else if (src_stb && src_d == `MRF_SFD_NIB)
            rx_state_ff <= RX_DATA;
        end
        RX_DATA:
        begin
          if (src_stb && (!src_dv || self_block))
          begin
            abort_ff <= self_block;
            flush_ff <= '0;
            rx_state_ff <= (cnt_ff >= `MRF_DA_NIBBLES) ? RX_FLUSH : RX_END;
          end
          else if (capture)
          begin
            if (cnt_ff != '1)
              cnt_ff <= cnt_ff + 1'b1;
            if (src_er)
              bad_ff <= 1'b1;
          end
          else if (src_er && src_stb)
            bad_ff <= 1'b1;
        end
        RX_FLUSH:
        begin
          flush_ff <= flush_ff + 4'h1;
          if (flush_ff == `MRF_FLUSH_LAST)
            rx_state_ff <= RX_END;
        end
        RX_END:
          rx_state_ff <= RX_IDLE;
        default:
          rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // Verdict is frozen once the destination is complete
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      fwd_ff <= 1'b0;
      pass_ff <= 1'b0;
    end
    else if (rx_state_ff == RX_IDLE)
    begin
      fwd_ff <= 1'b0;
      pass_ff <= 1'b0;
    end
    else if (rx_state_ff == RX_DATA && cnt_ff == `MRF_DA_NIBBLES)
    begin
      fwd_ff <= fwd_now;
      pass_ff <= pass_now;
    end
  end

  // Nibbles leave twelve behind arrival; rejected frames never raise valid
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      rx_data_out <= '0;
      rx_valid_out <= 1'b0;
    end
    else if (capture && cnt_ff >= `MRF_DA_NIBBLES)
    begin
      rx_data_out <= dly_ff[11];
      rx_valid_out <= fwd_use;
    end
    else if (rx_state_ff == RX_FLUSH)
    begin
      rx_data_out <= dly_ff[11];
      rx_valid_out <= fwd_ff;
    end
    else
      rx_valid_out <= 1'b0;
  end

  // End-of-frame status; damaged frames are kept only on request
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      rx_end_out <= 1'b0;
      rx_keep_out <= 1'b0;
      rx_filter_fail_out <= 1'b0;
      rx_bad_out <= 1'b0;
    end
    else
    begin
      rx_end_out <= rx_state_ff == RX_END;
      if (rx_state_ff == RX_END)
      begin
        rx_bad_out <= bad_ff | (cnt_ff < `MRF_MIN_FRAME_NIBBLES);
        rx_filter_fail_out <= ~pass_ff;
        rx_keep_out <= fwd_ff & ~abort_ff & (ctrl_ff[`MRF_BIT_FWD_DAMAGED]
          | ~(bad_ff | (cnt_ff < `MRF_MIN_FRAME_NIBBLES)));
      end
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  AST_RESERVED_ZERO:
    assert property ((ctrl_ff & ~`MRF_CTRL_WMASK) == '0)
    else $error("reserved control bits not zero");
  AST_LOOP_NO_PHY:
    assert property (loop_active_out |=> !mii_tx_en_out)
    else $error("PHY transmit enable raised during loopback");
  AST_LOOP_SETTLE:
    assert property ((ctrl_ff[`MRF_BIT_LOOP_SELECT] != loop_active_out)
      |-> ##[1:1000] (ctrl_ff[`MRF_BIT_LOOP_SELECT] == loop_active_out))
    else $error("loopback mode change took too long");
  AST_HB_MASK:
    assert property (ctrl_ff[`MRF_BIT_FULL_DUPLEX] |=> !hb_fail_out)
    else $error("heartbeat failure shown in full duplex");
  AST_FDX_NO_DEFER:
    assert property (ctrl_ff[`MRF_BIT_FULL_DUPLEX] |=> !tx_defer_out)
    else $error("full duplex transmit deferred");
  AST_SELF_BLOCK:
    assert property ((rx_state_ff == RX_DATA && self_block && src_stb) |=> rx_state_ff != RX_DATA)
    else $error("own frame not blocked");
  AST_PROMISC:
    assert property ((rx_state_ff == RX_DATA && cnt_ff == `MRF_DA_NIBBLES
      && ctrl_ff[`MRF_BIT_ANY_DEST]) |=> fwd_ff)
    else $error("promiscuous frame rejected");
  AST_MCAST:
    assert property ((rx_state_ff == RX_DATA && cnt_ff == `MRF_DA_NIBBLES
      && ctrl_ff[`MRF_BIT_PASS_MCAST] && da_ff[0]) |=> fwd_ff)
    else $error("multicast frame rejected");
  AST_INVERT:
    assert property ((rx_state_ff == RX_DATA && cnt_ff == `MRF_DA_NIBBLES
      && (ctrl_ff & `MRF_CTRL_WMASK) == 32'h0002_0000 && da_ff == station_addr_in) |=> !fwd_ff)
    else $error("inverse filter accepted a matching frame");
  AST_EXACT_DROP:
    assert property ((rx_state_ff == RX_DATA && cnt_ff == `MRF_DA_NIBBLES
      && (ctrl_ff & `MRF_CTRL_WMASK) == '0 && da_ff != station_addr_in) ##1 1'b1 [*2]
      |-> !rx_valid_out)
    else $error("non-matching frame forwarded");
  AST_BAD_DROP:
    assert property ((rx_state_ff == RX_END && !ctrl_ff[`MRF_BIT_FWD_DAMAGED] && bad_ff) |=> !rx_keep_out)
    else $error("damaged frame kept");
  AST_CSR_ACK:
    assert property (csr_sel_in |=> csr_ack_out ##1 (!csr_ack_out || $past(csr_sel_in)))
    else $error("CSR request not answered");

  COV_LOOP: cover property (loop_active_out && rx_end_out && rx_keep_out);
  COV_KEEP: cover property (rx_end_out && rx_keep_out && !rx_bad_out);
  COV_FILTER_FAIL: cover property (rx_end_out && rx_filter_fail_out);
  COV_SELF_BLOCK: cover property (rx_state_ff == RX_DATA && self_block && src_stb);
endmodule
`default_nettype wire

/* File: tb/mrf_phy_model.sv */
// PHY side of the MII receive path: plays nibble frames into the MAC.
// Assumes the bench calls send_frame; the receive clock stands still between frames.
`timescale 1ns/10ps
`default_nettype none
module mrf_phy_model (
  output var logic rx_clk_out,
  output var logic rx_dv_out,
  output var logic rx_er_out,
  output var logic col_out,
  output var logic [3:0] rxd_out
);
  // Quiet line levels before the first frame
  initial
  begin
    rx_clk_out = 1'b0;
    rx_dv_out = 1'b0;
    rx_er_out = 1'b0;
    col_out = 1'b0;
    rxd_out = 4'h0;
  end

  // One nibble per 80 ns; levels settle half a period before the rising edge
  task automatic put(input logic dv, input logic [3:0] d, input logic er, input logic cl);
    begin
      rx_dv_out = dv;
      rxd_out = d;
      rx_er_out = er;
      col_out = cl;
      #40 rx_clk_out = 1'b1;
      #40 rx_clk_out = 1'b0;
    end
  endtask

  // Preamble, start nibble, body, then one edge with dv low closes the frame
  task automatic send_frame(input logic [3:0] body[$], input int bad_at, input bit col);
    int i;
    begin
      for (i = 0; i < 7; i++)
        put(1'b1, 4'h5, 1'b0, 1'b0);
      put(1'b1, 4'hd, 1'b0, 1'b0);
      foreach (body[j])
        put(1'b1, body[j], j == bad_at && !col, j == bad_at && col);
      // Released data line shows the inverse so a stale nibble cannot pass
      put(1'b0, ~body[body.size()-1], 1'b0, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the MAC control register and receive filter.
// Assumes the PHY model drives the MII receive pins; the bench plays the MAC transmit side.
`timescale 1ns/10ps
`default_nettype none
`include "mrf_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import mrf_pkg::*;
  logic core_clk_in, resetn_in, csr_sel_in, csr_rnw_in, csr_ack_out, tx_stb_in, tx_en_in, heartbeat_fail_in;
  logic mii_rx_clk_in, mii_rx_dv_in, mii_rx_er_in, mii_col_in, mii_tx_en_out, rx_valid_out, rx_end_out;
  logic rx_keep_out, rx_filter_fail_out, rx_bad_out, hb_fail_out, tx_defer_out, loop_active_out;
  logic [7:0] csr_index_in;
  mrf_word_t csr_wdata_in, csr_rdata_out, rd_v;
  logic [47:0] station_addr_in, dh, dm;
  logic [63:0] hash_table_in;
  mrf_nib_t tx_data_in, mii_txd_out, rx_data_out, mii_rxd_in;
  int miscompares = 0, checks_done = 0, fwd = 0, txon = 0, dfr = 0, ends = 0, n, k;
  int seed = 32'hee43b224;

  mrf_mac_ctrl dut_u (.core_clk_in, .resetn_in, .csr_sel_in, .csr_rnw_in, .csr_index_in, .csr_wdata_in,
    .csr_ack_out, .csr_rdata_out, .station_addr_in, .hash_table_in, .tx_stb_in, .tx_en_in, .tx_data_in,
    .heartbeat_fail_in, .mii_rx_clk_in, .mii_rx_dv_in, .mii_rx_er_in, .mii_col_in, .mii_rxd_in,
    .mii_tx_en_out, .mii_txd_out, .rx_data_out, .rx_valid_out, .rx_end_out, .rx_keep_out,
    .rx_filter_fail_out, .rx_bad_out, .hb_fail_out, .tx_defer_out, .loop_active_out);

  mrf_phy_model phy_u (.rx_clk_out(mii_rx_clk_in), .rx_dv_out(mii_rx_dv_in), .rx_er_out(mii_rx_er_in),
    .col_out(mii_col_in), .rxd_out(mii_rxd_in));

  // 100 MHz core clock
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Counters of forwarded nibbles, PHY transmit cycles and deferral cycles
  always @(posedge core_clk_in)
  begin
    if (rx_valid_out === 1'b1) fwd++;
    if (mii_tx_en_out === 1'b1) txon++;
    if (tx_defer_out === 1'b1) dfr++;
    if (rx_end_out === 1'b1) ends++;
  end

  task automatic tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  // Hang guard, well beyond the expected run of about 33k cycles
  initial
  begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end

  // One CSR request; sel is a single-cycle pulse, ack awaited for a few cycles
  task automatic csr(input logic rnw, input logic [7:0] idx, input mrf_word_t wd);
    int i;
    begin
      @(negedge core_clk_in);
      csr_sel_in = 1'b1;
      csr_rnw_in = rnw;
      csr_index_in = idx;
      csr_wdata_in = wd;
      @(negedge core_clk_in);
      csr_sel_in = 1'b0;
      for (i = 0; i < 3 && csr_ack_out !== 1'b1; i++) @(negedge core_clk_in);
      rd_v = csr_rdata_out;
      `CHK("csr_ack", 1'b1, csr_ack_out)
    end
  endtask

  // Reflected CRC over the destination nibbles, low bit first; top six bits index the table
  function automatic logic [5:0] crc6(input logic [47:0] da);
    logic [31:0] c;
    int i;
    begin
      c = `MRF_CRC_INIT;
      for (i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ da[i]) ? `MRF_CRC_POLY : 32'h0);
      return c[31:26];
    end
  endfunction

  // Address decision: hash-all forces hashing, inverse only in exact mode
  function automatic logic addr_pass(input mrf_word_t c, input logic [47:0] da);
    logic m;
    begin
      m = ((da[0] ? c[13] : 1'b0) | c[15]) ? hash_table_in[crc6(da)] : (da == station_addr_in);
      if (!c[13] && !c[15] && c[17]) m = !m;
      return c[18] | (c[19] & da[0]) | m;
    end
  endfunction

  // MAC transmit nibbles: preamble, start nibble, data, then a strobe with enable low
  task automatic tx_send(input int len);
    int i;
    begin
      for (i = 0; i <= len; i++)
      begin
        @(negedge core_clk_in);
        tx_stb_in = 1'b1;
        tx_en_in = i < len;
        tx_data_in = (i < 7) ? 4'h5 : (i == 7) ? 4'hd : 4'($random(seed));
        @(negedge core_clk_in);
        tx_stb_in = 1'b0;
        repeat (6) @(negedge core_clk_in);
      end
    end
  endtask

  task automatic wait_end;
    int i;
    begin
      for (i = 0; i < 600 && rx_end_out !== 1'b1; i++) @(negedge core_clk_in);
      `CHK("rx_end", 1'b1, rx_end_out)
    end
  endtask

  // Program the mode, play one frame (optionally while transmitting) and check the status
  task automatic run_case(input mrf_word_t cfg, input logic [47:0] da, input int len, input int bad_at,
    input bit col, input bit txd);
    logic [3:0] b[$];
    logic p, bd, blk;
    int i;
    begin
      csr(1'b0, `MRF_IDX_CTRL, cfg);
      p = addr_pass(cfg, da);
      bd = (len < 128) | (bad_at >= 0);
      blk = txd & cfg[23];
      for (i = 0; i < len; i++) b.push_back(i < 12 ? da[4*i +: 4] : 4'($random(seed)));
      fwd = 0;
      txon = 0;
      dfr = 0;
      ends = 0;
      heartbeat_fail_in = 1'($random(seed));
      fork
        phy_u.send_frame(b, bad_at, col);
        if (txd)
        begin
          repeat (200) @(negedge core_clk_in);
          tx_send(20);
        end
      join
      // An own-frame abort ends the frame early; its remainder must not raise a second end
      if (!blk) wait_end();
      @(negedge core_clk_in);
      `CHK("ends", 1, ends)
      `CHK("keep", !blk & (p | cfg[31]) & (!bd | cfg[16]), rx_keep_out)
      `CHK("hb_fail", heartbeat_fail_in & !cfg[20], hb_fail_out)
      `CHK("defer", !cfg[20], dfr > 0)
      if (txd) `CHK("tx_on", 160, txon)
      if (!blk)
      begin
        `CHK("filter_fail", !p, rx_filter_fail_out)
        `CHK("bad", bd, rx_bad_out)
        `CHK("fwd", (p | cfg[31]) ? len : 0, fwd)
      end
      $display("case cfg %h done", cfg);
    end
  endtask

  // Main sequence
  initial
  begin
    resetn_in = 1'b0;
    {csr_sel_in, csr_rnw_in, tx_stb_in, tx_en_in} = 4'h0;
    csr_index_in = 8'h00;
    csr_wdata_in = 32'h0;
    tx_data_in = 4'h0;
    heartbeat_fail_in = 1'b1;
    station_addr_in = {16'($random(seed)), 32'($random(seed))} & ~48'h1;
    hash_table_in = {$random(seed), $random(seed)};
    repeat (6) @(negedge core_clk_in);
    resetn_in = 1'b1;
    csr(1'b1, `MRF_IDX_CTRL, 32'h0);
    `CHK("ctrl_reset", `MRF_CTRL_RESET, rd_v)
    csr(1'b0, `MRF_IDX_CTRL, 32'hffffffff);
    csr(1'b0, 8'h02, 32'h0);
    csr(1'b1, `MRF_IDX_CTRL, 32'h0);
    `CHK("ctrl_mask", `MRF_CTRL_WMASK, rd_v)
    csr(1'b1, 8'h02, 32'h0);
    `CHK("unmapped", 32'h0, rd_v)
    // The mask write touched loop select: put it back and let the mode settle
    csr(1'b0, `MRF_IDX_CTRL, 32'h0);
    repeat (1000) @(negedge core_clk_in);
    $display("register test done");
    // Exact, inverse, multicast, hash and bad-frame corner cases
    dh = station_addr_in ^ 48'h100;
    dm = {16'($random(seed)), 32'($random(seed))} | 48'h1;
    hash_table_in[crc6(dh)] = 1'b1;
    hash_table_in[crc6(dm)] = 1'b1;
    run_case(32'h0, station_addr_in, 128, -1, 0, 0);
    run_case(32'h0, dh, 128, -1, 0, 0);
    run_case(32'h00020000, dh, 128, -1, 0, 0);
    run_case(32'h00020000, station_addr_in, 128, -1, 0, 0);
    run_case(32'h00022000, dm, 128, -1, 0, 0);
    run_case(32'h00080000, dm ^ 48'h10, 128, -1, 0, 0);
    run_case(32'h00080000, dh, 128, -1, 0, 0);
    run_case(32'h00008000, dh, 128, -1, 0, 0);
    run_case(32'h00002000, dh, 128, -1, 0, 0);
    run_case(32'h00002000, dm, 128, -1, 0, 0);
    run_case(32'h00040000, dm, 128, -1, 0, 0);
    run_case(32'h80000000, dh, 128, -1, 0, 0);
    run_case(32'h00040000, dh, 40, -1, 0, 0);
    run_case(32'h00050000, dh, 40, -1, 0, 0);
    run_case(32'h00050000, dh, 128, 20, 0, 0);
    run_case(32'h00040000, dh, 128, 30, 1, 0);
    // Self-block set in half duplex; then clear in half and in full duplex
    run_case(32'h00840000, dh, 128, -1, 0, 1);
    run_case(32'h00040000, dh, 128, -1, 0, 1);
    run_case(32'h00140000, dh, 128, -1, 0, 1);
    // Random modes and destinations; self-block and loopback left out
    for (k = 0; k < 8; k++)
    begin
      dm = {16'($random(seed)), 32'($random(seed))};
      if ($random(seed) & 1) dm = station_addr_in;
      run_case($random(seed) & 32'h801fa000, dm, 128 + ($random(seed) & 15), -1, 0, 0);
    end
    // Loopback entered with transmit idle and full duplex selected
    csr(1'b0, `MRF_IDX_CTRL, 32'h00340000);
    for (n = 0; n < 1100 && loop_active_out !== 1'b1; n++) @(negedge core_clk_in);
    `CHK("loop_on", 1'b1, n >= 990 && n <= 1002)
    // Settling already waited out before transmitting again
    fwd = 0;
    txon = 0;
    tx_send(136);
    wait_end();
    `CHK("loop_fwd", 128, fwd)
    `CHK("loop_keep", 1'b1, rx_keep_out)
    `CHK("loop_tx_quiet", 0, txon)
    csr(1'b0, `MRF_IDX_CTRL, 32'h00140000);
    for (n = 0; n < 1100 && loop_active_out !== 1'b0; n++) @(negedge core_clk_in);
    `CHK("loop_off", 1'b1, n >= 990 && n <= 1002)
    $display("loopback test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
